// ### srlc_seq.v
`timescale 1ns/1ps
`default_nettype none
`include "srlc_defines.vh"
module srlc_seq #(
    parameter RELOAD_CYCLES = `SRLC_RELOAD_CYCLES,
    parameter BLINK_CYCLES  = `SRLC_BLINK_CYCLES
) (
    // Clock and reset
    input  wire        core_clk,
    input  wire        rst_b,
    // Control word access
    input  wire        ctrl_wr,
    input  wire [31:0] ctrl_wdata,
    output reg  [31:0] ctrl_rdata,
    // Strap
    input  wire        strap_pin_five,
    // Reload handshake with the EEPROM loader
    input  wire        eeprom_reload_done,
    output reg         eeprom_reload_start,
    // Link status for the indicators
    input  wire        link_up,
    input  wire        full_duplex,
    input  wire        speed_100,
    input  wire        tx_frame,
    input  wire        rx_frame,
    input  wire        collision,
    // Indicator lamps, active low
    output wire        power_indicator_out_b,
    output wire        link_indicator_out_b,
    output wire        duplex_indicator_out_b,
    output wire        speed_indicator_out_b,
    // External reset pin
    output reg         external_reset_pin,
    // Block reset strobes, high while held
    output reg         dma_rx_reset,
    output reg         dma_tx_reset,
    output reg         fifo_rx_reset,
    output reg         fifo_tx_reset,
    output reg         net_rx_reset,
    output reg         net_tx_reset,
    output reg         host_if_reset,
    output reg         eeprom_reload_select_reset,
    // One-cycle request to set the forced interrupt flag
    output reg         forced_irq_set
);
    // One-hot sequencer states
    localparam [2:0] ST_IDLE = 3'b001;
    localparam [2:0] ST_HOLD = 3'b010;
    localparam [2:0] ST_LOAD = 3'b100;

    localparam integer HOLD_INT = `SRLC_HOLD_CYCLES; // Hold length, full width
    localparam [7:0]  HOLD_LEN = HOLD_INT[7:0];      // Timer is 8 bits wide
    localparam [31:0] LOAD_MAX = RELOAD_CYCLES;

    reg [2:0]  state_q;           // Sequencer state
    reg        sim_fast_select_q; // Simulation speed-up bit
    reg        style_q;           // Indicator style select
    reg        pol_q;             // External reset active high
    reg        strap_done_q;      // Strap captured since reset
    reg        glob_q;            // Latched global request
    reg        rx_q;              // Latched receive request
    reg        tx_q;              // Latched transmit request
    reg [5:0]  sel_q;             // Latched selection bits
    reg [31:0] load_cnt_q;        // Reload timeout counter
    reg        busy_q;            // Reset in progress

    wire       tmr_load;          // Start hold timer
    wire       tmr_done;          // Hold timer expired
    wire       any_req;           // Write asks for some reset
    wire       take_req;          // Request accepted

    // Selection field bits
    wire sel_dma  = sel_q[0];
    wire sel_fifo = sel_q[1];
    wire sel_net  = sel_q[2];
    wire sel_host = sel_q[3];
    wire sel_load = sel_q[4];
    wire sel_out  = sel_q[5];

    assign any_req  = ctrl_wr & (ctrl_wdata[`SRLC_GLOBAL_BIT] |
                                 ctrl_wdata[`SRLC_RX_BIT] |
                                 ctrl_wdata[`SRLC_TX_BIT]);
    // Requests while busy are ignored so a running sequence is never cut short
    assign take_req = any_req & state_q[0];
    assign tmr_load = take_req;

    // Strap capture just after reset release; a clocked load keeps the
    // async reset branch to constants only
    always @(posedge core_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            strap_done_q      <= 1'b0;
            sim_fast_select_q <= `SRLC_SIM_FAST_RST;
        end
        else if (!strap_done_q)
        begin
            strap_done_q      <= 1'b1;
            sim_fast_select_q <= ~strap_pin_five; // R1
        end
        else if (ctrl_wr)
        begin
            sim_fast_select_q <= ctrl_wdata[`SRLC_SIM_FAST_BIT]; // R1
        end
    end

    // Plain read/write control bits
    always @(posedge core_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            style_q <= `SRLC_STYLE_RST; // R2
            pol_q   <= `SRLC_POL_RST;
        end
        else if (ctrl_wr)
        begin
            style_q <= ctrl_wdata[`SRLC_STYLE_BIT]; // R2
            pol_q   <= ctrl_wdata[`SRLC_POL_BIT];   // R7
        end
    end

    // Forced interrupt: one-cycle set strobe, the bit itself never stores
    always @(posedge core_clk or negedge rst_b)
    begin
        if (!rst_b)
            forced_irq_set <= 1'b0;
        else
            forced_irq_set <= ctrl_wr & ctrl_wdata[`SRLC_FORCE_IRQ_BIT]; // R19
    end

    // Hold timer for the reset pulse width
    srlc_timer #(
        .W (8)
    ) u_hold (
        .core_clk (core_clk),
        .rst_b    (rst_b),
        .load     (tmr_load),
        .load_val (HOLD_LEN),
        .running  (),
        .done     (tmr_done)
    );

    // Sequencer: latch request and selects, hold, optional EEPROM reload
    always @(posedge core_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            state_q             <= ST_IDLE;
            glob_q              <= 1'b0;
            rx_q                <= 1'b0;
            tx_q                <= 1'b0;
            sel_q               <= 6'h00;
            load_cnt_q          <= 32'h0000_0000;
            busy_q              <= 1'b0;
            eeprom_reload_start <= 1'b0;
        end
        else
        begin
            eeprom_reload_start <= 1'b0;
            case (state_q)
                ST_IDLE:
                begin
                    if (take_req)
                    begin
                        // Selects are taken with the request bits
                        glob_q  <= ctrl_wdata[`SRLC_GLOBAL_BIT];  // R8
                        rx_q    <= ctrl_wdata[`SRLC_RX_BIT];      // R10
                        tx_q    <= ctrl_wdata[`SRLC_TX_BIT];      // R11
                        sel_q   <= ctrl_wdata[`SRLC_SEL_EXTERNAL_RESET_PIN_BIT:`SRLC_SEL_DMA_BIT]; // R22
                        busy_q  <= 1'b1;                          // R20
                        state_q <= ST_HOLD;
                    end
                end
                ST_HOLD:
                begin
                    if (tmr_done)
                    begin
                        if (glob_q & sel_load)
                        begin
                            // Reload follows the hold; busy stays up meanwhile
                            eeprom_reload_start <= 1'b1; // R17
                            load_cnt_q          <= LOAD_MAX;
                            state_q             <= ST_LOAD;
                        end
                        else
                        begin
                            // Request and selects self-clear at the end
                            glob_q  <= 1'b0; // R8
                            rx_q    <= 1'b0; // R10
                            tx_q    <= 1'b0; // R11
                            sel_q   <= 6'h00; // R22
                            busy_q  <= 1'b0; // R20
                            state_q <= ST_IDLE;
                        end
                    end
                end
                ST_LOAD:
                begin
                    // Done from the loader, or a timeout so busy cannot stick
                    if (eeprom_reload_done || load_cnt_q == 32'h0000_0000)
                    begin
                        glob_q  <= 1'b0;
                        rx_q    <= 1'b0;
                        tx_q    <= 1'b0;
                        sel_q   <= 6'h00; // R22
                        busy_q  <= 1'b0;  // R20
                        state_q <= ST_IDLE;
                    end
                    else
                    begin
                        load_cnt_q <= load_cnt_q - 32'h0000_0001;
                    end
                end
                default:
                begin
                    state_q <= ST_IDLE;
                end
            endcase
        end
    end

    // Block reset strobes, held through the hold phase only.
    // Receive reset reaches receive halves, transmit reset transmit halves,
    // global reaches both; unselected blocks are left alone.
    // Configuration space has no strobe here at all. R9
    always @(posedge core_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            dma_rx_reset   <= 1'b0;
            dma_tx_reset   <= 1'b0;
            fifo_rx_reset  <= 1'b0;
            fifo_tx_reset  <= 1'b0;
            net_rx_reset   <= 1'b0;
            net_tx_reset   <= 1'b0;
            host_if_reset  <= 1'b0;
            eeprom_reload_select_reset <= 1'b0;
        end
        else
        begin
            // List pointers, done/active flags, early enable, receive state
            dma_rx_reset   <= state_q[1] & sel_dma & (glob_q | rx_q);  // R13
            dma_tx_reset   <= state_q[1] & sel_dma & (glob_q | tx_q);  // R13
            // Start, release and early thresholds
            fifo_rx_reset  <= state_q[1] & sel_fifo & (glob_q | rx_q); // R14
            fifo_tx_reset  <= state_q[1] & sel_fifo & (glob_q | tx_q); // R14
            // MAC core, receive mode, transmit status, statistics
            net_rx_reset   <= state_q[1] & sel_net & (glob_q | rx_q);  // R15
            net_tx_reset   <= state_q[1] & sel_net & (glob_q | tx_q);  // R15
            // Interrupt status, mask and countdown: global only
            host_if_reset  <= state_q[1] & sel_host & glob_q;          // R16
            eeprom_reload_select_reset <= state_q[1] & sel_load & glob_q;          // R17
        end
    end

    // External reset pin: active level from polarity, inactive otherwise
    always @(posedge core_clk or negedge rst_b)
    begin
        if (!rst_b)
            external_reset_pin <= 1'b1;
        else if (state_q[1] & sel_out & glob_q)
            external_reset_pin <= pol_q;  // R18
        else
            external_reset_pin <= ~pol_q; // R7
    end

    // Read-back: requests and selects show while held, busy bit live
    always @(posedge core_clk or negedge rst_b)
    begin
        if (!rst_b)
            ctrl_rdata <= 32'h0000_0000;
        else
        begin
            ctrl_rdata                        <= 32'h0000_0000;
            ctrl_rdata[`SRLC_SIM_FAST_BIT]    <= sim_fast_select_q;
            ctrl_rdata[`SRLC_STYLE_BIT]       <= style_q;
            ctrl_rdata[`SRLC_POL_BIT]         <= pol_q;
            ctrl_rdata[`SRLC_GLOBAL_BIT]      <= glob_q;
            ctrl_rdata[`SRLC_RX_BIT]          <= rx_q;
            ctrl_rdata[`SRLC_TX_BIT]          <= tx_q;
            ctrl_rdata[`SRLC_SEL_EXTERNAL_RESET_PIN_BIT:`SRLC_SEL_DMA_BIT] <= sel_q;
            ctrl_rdata[`SRLC_BUSY_BIT]        <= busy_q; // R20
        end
    end

    // Indicator causes per style
    wire pwr_act  = ~style_q & tx_frame;                           // R3
    wire link_act = link_up & (rx_frame | (style_q & tx_frame));   // R4

    // Power lamp
    srlc_led #(
        .BLINK_CYCLES (BLINK_CYCLES)
    ) u_led_pwr (
        .core_clk  (core_clk),
        .rst_b     (rst_b),
        .steady_on (1'b1),     // R3
        .activity  (pwr_act),
        .lamp_b    (power_indicator_out_b)
    );

    // Link lamp
    srlc_led #(
        .BLINK_CYCLES (BLINK_CYCLES)
    ) u_led_link (
        .core_clk  (core_clk),
        .rst_b     (rst_b),
        .steady_on (link_up),  // R4
        .activity  (link_act),
        .lamp_b    (link_indicator_out_b)
    );

    // Duplex lamp, same in both styles
    srlc_led #(
        .BLINK_CYCLES (BLINK_CYCLES)
    ) u_led_dplx (
        .core_clk  (core_clk),
        .rst_b     (rst_b),
        .steady_on (full_duplex), // R5
        .activity  (collision),   // R5
        .lamp_b    (duplex_indicator_out_b)
    );

    // Speed lamp never flashes
    srlc_led #(
        .BLINK_CYCLES (BLINK_CYCLES)
    ) u_led_spd (
        .core_clk  (core_clk),
        .rst_b     (rst_b),
        .steady_on (speed_100),   // R6
        .activity  (1'b0),
        .lamp_b    (speed_indicator_out_b)
    );
endmodule // srlc_seq
`default_nettype wire

// ### srlc_defines.vh
// What this block does
// R1: Speed-up bit loads inverted strap, then writable
// R2: Indicator style bit resets to mode 0
// R3: Power light steady, flashes on transmit in mode 0
// R4: Link light steady when up, flashes on receive, and on transmit too in mode 1
// R5: Duplex light steady full duplex, flashes collisions
// R6: Speed light on at 100, off at 10
// R7: Polarity bit picks external reset active level
// R8: Global reset hits only selected blocks, self-clears
// R9: Configuration space untouched by global reset
// R10: Receive reset hits selected receive logic, self-clears
// R11: Transmit reset hits selected transmit logic, self-clears
// R12: Host resets transmit after underrun; receive sparingly
// R13: DMA select clears list pointers and flags
// R14: FIFO select resets thresholds
// R15: Network select resets MAC, mode, status, statistics
// R16: Host select needs global; clears interrupt registers
// R17: Reload select needs global; restarts EEPROM load
// R18: Reset-output select needs global; drives pin with polarity
// R19: Interrupt request bit sets flag, self-clears
// R20: Busy bit reads one while reset runs
// R21: Host polls busy until zero
// R22: Selects sampled with request, cleared at completion
`ifndef SRLC_DEFINES_VH
`define SRLC_DEFINES_VH

// Bit positions inside the control word
`define SRLC_SIM_FAST_BIT       13
`define SRLC_STYLE_BIT          14
`define SRLC_POL_BIT            15
`define SRLC_GLOBAL_BIT         16
`define SRLC_RX_BIT             17
`define SRLC_TX_BIT             18
`define SRLC_SEL_DMA_BIT        19
`define SRLC_SEL_FIFO_BIT       20
`define SRLC_SEL_NET_BIT        21
`define SRLC_SEL_HOST_BIT       22
`define SRLC_SEL_RELOAD_BIT     23
`define SRLC_SEL_EXTERNAL_RESET_PIN_BIT     24
`define SRLC_FORCE_IRQ_BIT      25
`define SRLC_BUSY_BIT           26

// Reset values of the control bits
`define SRLC_STYLE_RST          1'b0
`define SRLC_POL_RST            1'b0
`define SRLC_SIM_FAST_RST       1'b0

// Timing
`define SRLC_CLK_PERIOD_PS      4000
`define SRLC_HOLD_NS            100
`define SRLC_HOLD_CYCLES        (((`SRLC_HOLD_NS) * 1000 + `SRLC_CLK_PERIOD_PS - 1) / `SRLC_CLK_PERIOD_PS)
`define SRLC_RELOAD_MAX_US      1000
`define SRLC_RELOAD_CYCLES      (((`SRLC_RELOAD_MAX_US) * 1000000) / `SRLC_CLK_PERIOD_PS)
`define SRLC_BLINK_MS           30
`define SRLC_BLINK_CYCLES       (((`SRLC_BLINK_MS) * 1000000) / (`SRLC_CLK_PERIOD_PS / 1000))

`endif

// ### srlc_timer.v
`timescale 1ns/1ps
`default_nettype none
module srlc_timer #(
    parameter W = 8
) (
    // Clock and reset
    input  wire         core_clk,
    input  wire         rst_b,
    // Control
    input  wire         load,
    input  wire [W-1:0] load_val,
    // Status
    output reg          running,
    output reg          done
);
    reg [W-1:0] cnt_q;  // Remaining cycles

    // Down counter, one-cycle done pulse at expiry
    always @(posedge core_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            cnt_q   <= {W{1'b0}};
            running <= 1'b0;
            done    <= 1'b0;
        end
        else if (load)
        begin
            // Reload restarts the count
            cnt_q   <= load_val;
            running <= 1'b1;
            done    <= 1'b0;
        end
        else if (running)
        begin
            cnt_q   <= cnt_q - {{(W-1){1'b0}}, 1'b1};
            running <= (cnt_q != {{(W-1){1'b0}}, 1'b1});
            done    <= (cnt_q == {{(W-1){1'b0}}, 1'b1});
        end
        else
        begin
            done <= 1'b0;
        end
    end
endmodule // srlc_timer
`default_nettype wire

// ### srlc_led.v
`timescale 1ns/1ps
`default_nettype none
module srlc_led #(
    parameter BLINK_CYCLES = 7500000
) (
    // Clock and reset
    input  wire core_clk,
    input  wire rst_b,
    // Indicator causes
    input  wire steady_on,
    input  wire activity,
    // Active-low lamp drive
    output reg  lamp_b
);
    reg [31:0] phase_q;  // Blink half-period counter
    reg        blink_q;  // Blink phase
    reg        busy_q;   // Flashing window open

    // Activity opens a flash window; window closes at the end of the half period holding the last activity
    always @(posedge core_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            phase_q <= 32'h0000_0000;
            blink_q <= 1'b0;
            busy_q  <= 1'b0;
            lamp_b  <= 1'b1;
        end
        else
        begin
            if (activity & ~busy_q)
            begin
                // Fresh window opens dark, so a single short frame still shows
                phase_q <= 32'h0000_0000;
                blink_q <= 1'b1;
                busy_q  <= 1'b1;
            end
            else if (phase_q >= BLINK_CYCLES - 1)
            begin
                // Half period over: toggle, close if quiet
                phase_q <= 32'h0000_0000;
                blink_q <= ~blink_q;
                busy_q  <= activity;
            end
            else
            begin
                phase_q <= phase_q + 32'h0000_0001;
                busy_q  <= busy_q | activity;
            end
            // Flash overrides steady light
            if (busy_q)
                lamp_b <= blink_q;
            else
                lamp_b <= ~steady_on;
        end
    end
endmodule // srlc_led
`default_nettype wire

// ### srlc_seq_chk.sv
`timescale 1ns/1ps
`default_nettype none
module srlc_seq_chk #(
    parameter RELOAD_CYCLES = 50
) (
    // Clock and reset
    input wire logic        core_clk,
    input wire logic        rst_b,
    // Control word
    input wire logic        ctrl_wr,
    input wire logic [31:0] ctrl_wdata,
    input wire logic [31:0] ctrl_rdata,
    // Pulses and pins
    input wire logic        forced_irq_set,
    input wire logic        eeprom_reload_start,
    input wire logic        external_reset_pin,
    input wire logic        power_indicator_out_b,
    input wire logic        speed_indicator_out_b,
    input wire logic        speed_100,
    // Block strobes
    input wire logic        dma_rx_reset,
    input wire logic        fifo_tx_reset,
    input wire logic        net_rx_reset,
    input wire logic        host_if_reset,
    input wire logic        eeprom_reload_select_reset
);
    // Hold, reload wait and some pipeline slack
    localparam int BUSY_MAX = 25 + RELOAD_CYCLES + 20;
    // Read image alias
    wire [31:0]  r = ctrl_rdata;
    // Busy span counter
    logic [15:0] busy_q;
    logic [15:0] busy_d;

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_b);

    // Counts cycles with busy read high
    always_comb busy_d = r[26] ? busy_q + 16'h0001 : 16'h0000;

    // Counter flop
    always_ff @(posedge core_clk or negedge rst_b)
        if (!rst_b)
            busy_q <= 16'h0000;
        else
            busy_q <= busy_d;

    irq_pulse_a: assert property (ctrl_wr && ctrl_wdata[25] |=> forced_irq_set)
        else $error("forced irq pulse missing");
    irq_cause_a: assert property (forced_irq_set |-> $past(ctrl_wr && ctrl_wdata[25]))
        else $error("forced irq pulse without request");
    reserved_zero_a: assert property (r[25] == 1'b0 && r[31:27] == 5'h00 && r[12:0] == 13'h0)
        else $error("self clearing or reserved bit reads one");
    req_busy_a: assert property (ctrl_wr && ctrl_wdata[16] && !r[26] && !$past(r[26])
        && !$past(ctrl_wr) |-> ##2 r[26]) else $error("busy not shown after reset request");
    busy_bound_a: assert property (busy_q < BUSY_MAX)
        else $error("busy held too long");
    sel_clear_a: assert property ($fell(r[26]) |-> r[24:16] == 9'h000)
        else $error("request or select bits left set");
    dma_sel_a: assert property ($rose(dma_rx_reset) |-> r[19] && (r[16] || r[17]))
        else $error("dma strobe without its select");
    fifo_sel_a: assert property ($rose(fifo_tx_reset) |-> r[20] && (r[16] || r[18]))
        else $error("fifo strobe without its select");
    net_sel_a: assert property ($rose(net_rx_reset) |-> r[21] && (r[16] || r[17]))
        else $error("network strobe without its select");
    host_sel_a: assert property ($rose(host_if_reset) |-> r[22] && r[16])
        else $error("host strobe without global reset");
    reload_sel_a: assert property ($rose(eeprom_reload_select_reset) || eeprom_reload_start
        |-> r[23] && r[16]) else $error("reload without global reset");
    external_reset_pin_pol_a: assert property ($rose(r[26]) |-> ##1
        external_reset_pin == !(r[15] ^ (r[16] && r[24]))) else $error("reset pin level wrong");
    pin_idle_a: assert property (!r[26] && !$past(r[26]) && !$past(r[26], 2) && !$past(ctrl_wr)
        && !$past(ctrl_wr, 2) |-> external_reset_pin == !r[15]) else $error("idle pin level");
    speed_lamp_a: assert property ($past(rst_b)
        |-> speed_indicator_out_b == !$past(speed_100)) else $error("speed lamp wrong");
    power_mode1_a: assert property (r[14] && $past(r[14]) && $past(r[14], 2)
        |-> !power_indicator_out_b) else $error("power lamp off in mode 1");
endmodule // srlc_seq_chk

bind srlc_seq srlc_seq_chk #(.RELOAD_CYCLES(RELOAD_CYCLES)) u_chk (
    .core_clk, .rst_b, .ctrl_wr, .ctrl_wdata, .ctrl_rdata,
    .forced_irq_set, .eeprom_reload_start, .external_reset_pin,
    .power_indicator_out_b, .speed_indicator_out_b, .speed_100, .dma_rx_reset,
    .fifo_tx_reset, .net_rx_reset, .host_if_reset, .eeprom_reload_select_reset
);
`default_nettype wire

// ### tb_srlc_seq.sv
`timescale 1ns/1ps
`default_nettype none
module tb_srlc_seq;
    // Clock, reset and control word
    logic        core_clk;
    logic        rst_b;
    logic        ctrl_wr;
    logic [31:0] ctrl_wdata;
    wire  [31:0] ctrl_rdata;
    // Strap, loader and link inputs
    logic        strap;
    logic        rl_done;
    logic        rl_seen;
    logic        link_up;
    logic        fdx;
    logic        spd;
    logic        txf;
    logic        rxf;
    logic        col;
    // Outputs
    wire         rl_start;
    wire         pwr_b;
    wire         lnk_b;
    wire         dpx_b;
    wire         spd_b;
    wire         rst_pin;
    wire         irq_set;
    wire  [7:0]  strb;
    int          miscompares;
    int          checks;
    // Reset requests and the strobes, pin and reload each must give
    logic [31:0] rd_tab [10] = '{32'h0009_0000, 32'h0031_0000, 32'h0041_0000,
        32'h0081_0000, 32'h0101_0000, 32'h0101_8000, 32'h0001_0000, 32'h01fa_0000,
        32'h003c_0000, 32'h0006_0000};
    logic [9:0]  re_tab [10] = '{10'h300, 10'h0f0, 10'h008, 10'h005, 10'h002,
        10'h002, 10'h000, 10'h2a0, 10'h150, 10'h000};
    // Lamps {power, link, duplex} expected to flash
    logic [2:0]  fl_tab [6] = '{3'h4, 3'h2, 3'h1, 3'h2, 3'h2, 3'h1};

    srlc_seq #(.RELOAD_CYCLES(50), .BLINK_CYCLES(4)) dut_u (
        .core_clk(core_clk), .rst_b(rst_b), .ctrl_wr(ctrl_wr), .ctrl_wdata(ctrl_wdata),
        .ctrl_rdata(ctrl_rdata), .strap_pin_five(strap), .eeprom_reload_done(rl_done),
        .eeprom_reload_start(rl_start), .link_up(link_up), .full_duplex(fdx),
        .speed_100(spd), .tx_frame(txf), .rx_frame(rxf), .collision(col),
        .power_indicator_out_b(pwr_b), .link_indicator_out_b(lnk_b),
        .duplex_indicator_out_b(dpx_b), .speed_indicator_out_b(spd_b),
        .external_reset_pin(rst_pin), .dma_rx_reset(strb[7]), .dma_tx_reset(strb[6]),
        .fifo_rx_reset(strb[5]), .fifo_tx_reset(strb[4]), .net_rx_reset(strb[3]),
        .net_tx_reset(strb[2]), .host_if_reset(strb[1]), .eeprom_reload_select_reset(strb[0]),
        .forced_irq_set(irq_set)
    );

    // Free running clock
    initial
    begin
        core_clk = 1'b0;
        forever #2 core_clk = ~core_clk;
    end

    // Loader answers six cycles after each start pulse
    initial
    forever
    begin
        @(posedge core_clk iff rl_start === 1'b1);
        rl_seen = 1'b1;
        repeat (6) @(negedge core_clk);
        rl_done = 1'b1;
        @(negedge core_clk);
        rl_done = 1'b0;
    end

    // Compare and count
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        checks++;
        if (g !== e)
        begin
            miscompares++;
            $display("[ERR] %s expected %h seen %h", nm, e, g);
        end
    endtask

    // Verdict and end of run
    task automatic conclude;
        $display("checks %0d miscompares %0d", checks, miscompares);
        if (miscompares == 0 && checks > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask

    // Wait whole cycles
    task automatic idle(input int n);
        repeat (n) @(negedge core_clk);
    endtask

    // One write strobe
    task automatic wr(input logic [31:0] d);
        @(negedge core_clk);
        ctrl_wr = 1'b1;
        ctrl_wdata = d;
        @(negedge core_clk);
        ctrl_wr = 1'b0;
    endtask

    // Values after reset, then the speed-up bit overwritten
    task automatic t_reset;
        idle(3);
        chk("sim_fast", 32'h1, ctrl_rdata[13]);
        chk("style", 32'h0, ctrl_rdata[14]);
        chk("ext_pin", 32'h1, rst_pin);
        chk("power_lamp", 32'h0, pwr_b);
        wr(32'h0000_0000);
        idle(3);
        chk("sim_fast_wr", 32'h0, ctrl_rdata[13]);
    endtask

    // Forced interrupt pulse lasts one cycle: irq_set high after the write, low one cycle later
    task automatic t_irq;
        wr(32'h0200_0000);
        chk("irq_set", 32'h1, irq_set);
        @(negedge core_clk);
        chk("irq_end", 32'h0, irq_set);
    endtask

    // One reset request; optional refused request while busy
    task automatic t_rst(input logic [31:0] d, input logic [9:0] e, input bit rej);
        logic [9:0] seen;
        int         n;
        seen = 10'h000;
        n = 0;
        rl_seen = 1'b0;
        wr(d);
        while ((n < 4 || ctrl_rdata[26] === 1'b1) && n < 300)
        begin
            if (n > 1)
                seen = seen | {strb, rst_pin === d[15], 1'b0};
            if (rej && n == 5)
                wr((d & 32'h0000_e000) | 32'h000a_0000);
            n++;
            @(negedge core_clk);
        end
        seen[0] = rl_seen;
        chk("busy_end", 32'h0, ctrl_rdata[26]);
        chk("strobes", e, seen);
        chk("sel_clear", 32'h0, ctrl_rdata[24:16]);
        chk("pin_idle", !d[15], rst_pin);
    endtask

    // Speed and link lamps follow their levels
    task automatic t_speed;
        spd = 1'b1;
        idle(4);
        chk("speed_on", 32'h0, spd_b);
        spd = 1'b0;
        link_up = 1'b0;
        idle(4);
        chk("speed_off", 32'h1, spd_b);
        chk("link_off", 32'h1, lnk_b);
        link_up = 1'b1;
    endtask

    // Activity in one mode, then see which lamps flashed
    task automatic t_flash(input int s, input bit m, input logic [2:0] e);
        logic [2:0] seen;
        seen = 3'h0;
        wr({17'h0, m, 14'h0});
        idle(30);
        chk("lamps_on", 32'h0, {pwr_b, lnk_b, dpx_b});
        txf = (s == 0);
        rxf = (s == 1);
        col = (s == 2);
        @(negedge core_clk);
        txf = 1'b0;
        rxf = 1'b0;
        col = 1'b0;
        repeat (20)
        begin
            @(negedge core_clk);
            seen = seen | {pwr_b, lnk_b, dpx_b};
        end
        chk("flash", e, seen);
    endtask

    // Second reset with the strap high; style returns to mode 0
    task automatic t_rereset;
        strap = 1'b1;
        rst_b = 1'b0;
        idle(3);
        rst_b = 1'b1;
        idle(3);
        chk("strap_again", 32'h0, ctrl_rdata[13]);
        chk("style_again", 32'h0, ctrl_rdata[14]);
    endtask

    // Main sequence
    initial
    begin
        rst_b = 1'b0;
        ctrl_wr = 1'b0;
        ctrl_wdata = 32'h0;
        strap = 1'b0;
        rl_done = 1'b0;
        rl_seen = 1'b0;
        link_up = 1'b1;
        fdx = 1'b1;
        spd = 1'b0;
        txf = 1'b0;
        rxf = 1'b0;
        col = 1'b0;
        repeat (3) @(negedge core_clk);
        rst_b = 1'b1;
        t_reset();
        t_irq();
        for (int i = 0; i < 10; i++)
            t_rst(rd_tab[i], re_tab[i], i == 3);
        t_speed();
        for (int i = 0; i < 6; i++)
            t_flash(i % 3, i / 3, fl_tab[i]);
        t_rereset();
        conclude();
    end

    // Watchdog well past the expected run length
    initial
    begin
        #100000;
        miscompares++;
        conclude();
    end
endmodule // tb_srlc_seq
`default_nettype wire
